// [shared/tmcp_cfg.svh]
// Purpose: register indices, field positions, reset values and counts for the timer
// Assumes: register byte address is four times the register index
// Notes: definitions only
`ifndef TMCP_CFG_SVH
`define TMCP_CFG_SVH

// register indices; byte address = index * 4
`define TMCP_IDX_COUNT 12'hf00
`define TMCP_IDX_RELOAD 12'hf02
`define TMCP_IDX_PWM 12'hf04
`define TMCP_IDX_CTL0 12'hf06
`define TMCP_IDX_CTL1_T0 12'hf07
`define TMCP_IDX_CTL1_T1 12'hf0f
`define TMCP_IDX_STATUS 12'hf10
`define TMCP_IDX_MASK 12'hf11

// reset values
`define TMCP_RST_CTL 8'h00
`define TMCP_RST_COUNT 16'h0001
`define TMCP_RST_RELOAD 16'hffff
`define TMCP_RST_PWM 16'h0000
`define TMCP_RESTART 16'h0001

// interrupt status bit positions
`define TMCP_ST_RELOAD 0
`define TMCP_ST_CAPTURE 1
`define TMCP_ST_GATE 2
`define TMCP_ST_W 3

// interrupt event config codes
`define TMCP_ICFG_DEASSERT 2'h2
`define TMCP_ICFG_RELOAD 2'h3

`endif

// [shared/tmcp_pkg.sv]
// Purpose: types shared by the timer design
// Assumes: constants live in tmcp_cfg.svh
// Notes: operating mode codes 0..7 sit in control one, bit 3 in control zero
package tmcp_pkg;

  typedef enum logic [3:0] {
    TMCP_ONE_SHOT = 4'h0,
    TMCP_CONTINUOUS = 4'h1,
    TMCP_COUNTER = 4'h2,
    TMCP_PWM_SINGLE = 4'h3,
    TMCP_CAPTURE = 4'h4,
    TMCP_COMPARE = 4'h5,
    TMCP_GATED = 4'h6,
    TMCP_CAPT_CMP = 4'h7,
    TMCP_PWM_DUAL = 4'h8,
    TMCP_CAPT_RESTART = 4'h9,
    TMCP_CMP_COUNTER = 4'ha
  } tmcp_mode_t;

  typedef struct packed {
    logic timer_run_enable;
    logic input_output_polarity;
    logic [2:0] prescale_select;
    logic [2:0] mode_low;
  } tmcp_ctl1_t;

  typedef struct packed {
    logic mode_high;
    logic [1:0] interrupt_event_config;
    logic reserved;
    logic [2:0] dead_time_select;
    logic capture_cause_flag;
  } tmcp_ctl0_t;

  // capture/compare start sequence
  typedef enum logic [1:0] {
    TMCP_CC_WAIT = 2'b00,
    TMCP_CC_RUN = 2'b01
  } tmcp_cc_state_t;

endpackage

// [core/tmcp_timer.sv]
// Purpose: 16-bit timer with prescaler, modes, polarity and apb register access
// Assumes: timer input already synchronous to clock; apb slave, 32-bit data
// Notes: one timer per instance; second timer uses the other control one index
//
// How it works
// - gated restarts count from 0001 after reset
// - gated interrupt on deassert and reload, configurable
// - capture/compare starts on first polarity edge
// - capture/compare counts the prescaled system clock
// - later capture/compare edges copy count to pwm
// - capture: interrupt, reload 0001, flag set
// - compare reach: interrupt, reload 0001, flag clear
// - enable bit 7 of control one
// - toggle modes: idle at polarity, toggle on reload
// - counter counts polarity-selected input edges
// - single pwm: match and reload levels
// - capture edge chosen by polarity
// - gated counts at level, interrupts on deassert
// - dual pwm: output and complement levels
// - dual pwm dead time before active level
// - mode codes 1000, 1001, 1010 decoded
// - capture cause flag tracks last interrupt source
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`include "tmcp_cfg.svh"

module tmcp_timer #(
  parameter logic [11:0] CTL1_INDEX = `TMCP_IDX_CTL1_T0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_input,
  output logic timer_out,
  output logic timer_out_comp,
  output logic irq
);

  tmcp_pkg::tmcp_ctl1_t ctl1_q;
  tmcp_pkg::tmcp_ctl0_t ctl0_q;
  tmcp_pkg::tmcp_mode_t mode;
  tmcp_pkg::tmcp_cc_state_t cc_q;
  logic [15:0] count_q;
  logic [15:0] reload_q;
  logic [15:0] pwm_q;
  logic [`TMCP_ST_W-1:0] status_q;
  logic [`TMCP_ST_W-1:0] mask_q;
  logic [`TMCP_ST_W-1:0] ev;
  logic [6:0] pre_q;
  logic tin_q;
  logic out_raw_q;
  logic out_q;
  logic comp_q;
  logic [7:0] dead_q;
  logic [7:0] dead_now;
  logic raw_seen_q;
  logic ready_q;
  logic [31:0] rdata_q;
  logic [11:0] idx;
  logic mapped;
  logic wr;
  logic en;
  logic pol;
  logic tick;
  logic rise;
  logic fall;
  logic act_edge;
  logic deassert;
  logic at_reload;
  logic pwm_match;
  logic advance;
  logic reload_ev;
  logic capture_ev;
  logic gate_ev;
  logic cc_start;
  logic toggle_mode;

  // low bits of prescale counter that must be all ones for a tick
  function automatic logic [6:0] presc_mask(input logic [2:0] sel);
    presc_mask = 7'((8'h01 << sel) - 8'h01);
  endfunction

  // dead time in cycles; code 0 means none, code k gives 2^k
  function automatic logic [7:0] dead_cycles(input logic [2:0] sel);
    dead_cycles = (sel == 3'h0) ? 8'h00 : 8'(9'h001 << sel);
  endfunction

  // register index is the word address
  function automatic logic [11:0] word_index(input logic [13:0] a);
    word_index = a[13:2];
  endfunction

  assign idx = word_index(paddr);
  assign mapped = idx == `TMCP_IDX_COUNT || idx == `TMCP_IDX_RELOAD || idx == `TMCP_IDX_PWM ||
                  idx == `TMCP_IDX_CTL0 || idx == CTL1_INDEX || idx == `TMCP_IDX_STATUS ||
                  idx == `TMCP_IDX_MASK;
  assign wr = psel && penable && pwrite && ready_q && mapped;

  // mode is the four-bit field split over both controls
  assign mode = tmcp_pkg::tmcp_mode_t'({ctl0_q.mode_high, ctl1_q.mode_low});
  assign en = ctl1_q.timer_run_enable;
  assign pol = ctl1_q.input_output_polarity;

  // input edge detection; input is taken as synchronous
  assign rise = timer_input && !tin_q;
  assign fall = !timer_input && tin_q;
  assign act_edge = pol ? fall : rise;
  // gate deasserts when input returns to the polarity level
  assign deassert = pol ? rise : fall;

  // prescaled tick, only while enabled
  assign tick = en && ((pre_q & presc_mask(ctl1_q.prescale_select)) == presc_mask(ctl1_q.prescale_select));

  // what advances the count in each mode
  always_comb begin
    case (mode)
      tmcp_pkg::TMCP_COUNTER, tmcp_pkg::TMCP_CMP_COUNTER: begin
        advance = en && act_edge;
      end
      tmcp_pkg::TMCP_GATED: begin
        advance = tick && (timer_input != pol);
      end
      tmcp_pkg::TMCP_CAPT_CMP: begin
        advance = tick && cc_q == tmcp_pkg::TMCP_CC_RUN;
      end
      default: begin
        advance = tick;
      end
    endcase
  end

  assign at_reload = count_q == reload_q;
  assign pwm_match = count_q == pwm_q;
  assign reload_ev = advance && at_reload;
  assign cc_start = en && mode == tmcp_pkg::TMCP_CAPT_CMP && cc_q == tmcp_pkg::TMCP_CC_WAIT && act_edge;
  // capture in capture, restart and capture/compare (after the first edge) modes
  assign capture_ev = en && act_edge && (mode == tmcp_pkg::TMCP_CAPTURE || mode == tmcp_pkg::TMCP_CAPT_RESTART ||
                      (mode == tmcp_pkg::TMCP_CAPT_CMP && cc_q == tmcp_pkg::TMCP_CC_RUN));
  assign gate_ev = en && mode == tmcp_pkg::TMCP_GATED && deassert;
  assign toggle_mode = mode == tmcp_pkg::TMCP_ONE_SHOT || mode == tmcp_pkg::TMCP_CONTINUOUS ||
                       mode == tmcp_pkg::TMCP_COMPARE || mode == tmcp_pkg::TMCP_COUNTER ||
                       mode == tmcp_pkg::TMCP_CMP_COUNTER;

  // interrupt events; gated mode can limit to one source
  always_comb begin
    ev = '0;
    ev[`TMCP_ST_RELOAD] = reload_ev;
    ev[`TMCP_ST_CAPTURE] = capture_ev;
    ev[`TMCP_ST_GATE] = gate_ev;
    if (mode == tmcp_pkg::TMCP_GATED) begin
      if (ctl0_q.interrupt_event_config == `TMCP_ICFG_DEASSERT) begin
        ev[`TMCP_ST_RELOAD] = 1'b0;
      end
      if (ctl0_q.interrupt_event_config == `TMCP_ICFG_RELOAD) begin
        ev[`TMCP_ST_GATE] = 1'b0;
      end
    end
  end

  // free-running prescale counter, cleared while disabled for a known phase
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pre_q <= 7'h00;
    end else if (!en) begin
      pre_q <= 7'h00;
    end else begin
      pre_q <= pre_q + 7'h01;
    end
  end

  // input history for edges
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tin_q <= 1'b0;
    end else begin
      tin_q <= timer_input;
    end
  end

  // capture/compare waits for first edge; disable rearms it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cc_q <= tmcp_pkg::TMCP_CC_WAIT;
    end else begin
      case (cc_q)
        tmcp_pkg::TMCP_CC_WAIT: begin
          if (cc_start) begin
            cc_q <= tmcp_pkg::TMCP_CC_RUN;
          end
        end
        tmcp_pkg::TMCP_CC_RUN: begin
          if (!en || mode != tmcp_pkg::TMCP_CAPT_CMP) begin
            cc_q <= tmcp_pkg::TMCP_CC_WAIT;
          end
        end
        default: begin
          cc_q <= tmcp_pkg::TMCP_CC_WAIT;
        end
      endcase
    end
  end

  // count; software write wins, so reconfigure only while disabled
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_q <= `TMCP_RST_COUNT;
    end else if (wr && idx == `TMCP_IDX_COUNT) begin
      count_q <= pwdata[15:0];
    end else if (capture_ev && mode != tmcp_pkg::TMCP_CAPTURE) begin
      count_q <= `TMCP_RESTART;
    end else if (reload_ev || gate_ev) begin
      count_q <= `TMCP_RESTART;
    end else if (advance) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // capture register, also the pwm compare value
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pwm_q <= `TMCP_RST_PWM;
    end else if (capture_ev) begin
      pwm_q <= count_q;
    end else if (wr && idx == `TMCP_IDX_PWM) begin
      pwm_q <= pwdata[15:0];
    end
  end

  // reload / compare value
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reload_q <= `TMCP_RST_RELOAD;
    end else if (wr && idx == `TMCP_IDX_RELOAD) begin
      reload_q <= pwdata[15:0];
    end
  end

  // control one; one-shot clears its own enable at reload
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctl1_q <= `TMCP_RST_CTL;
    end else if (wr && idx == CTL1_INDEX) begin
      ctl1_q <= pwdata[7:0];
    end else if (reload_ev && mode == tmcp_pkg::TMCP_ONE_SHOT) begin
      ctl1_q.timer_run_enable <= 1'b0;
    end
  end

  // control zero; cause flag is hardware owned
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctl0_q <= `TMCP_RST_CTL;
    end else begin
      if (wr && idx == `TMCP_IDX_CTL0) begin
        ctl0_q.mode_high <= pwdata[7];
        ctl0_q.interrupt_event_config <= pwdata[6:5];
        ctl0_q.dead_time_select <= pwdata[3:1];
      end
      if (capture_ev) begin
        ctl0_q.capture_cause_flag <= 1'b1;
      end else if (reload_ev || gate_ev) begin
        ctl0_q.capture_cause_flag <= 1'b0;
      end
    end
  end

  // raw output level before dead time
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      out_raw_q <= 1'b0;
    end else if (!en) begin
      out_raw_q <= pol;
    end else if (mode == tmcp_pkg::TMCP_PWM_SINGLE || mode == tmcp_pkg::TMCP_PWM_DUAL) begin
      if (reload_ev) begin
        out_raw_q <= pol;
      end else if (advance && pwm_match) begin
        out_raw_q <= !pol;
      end
    end else if (toggle_mode && reload_ev) begin
      out_raw_q <= !out_raw_q;
    end
  end

  // dead-time counter restarts on a raw flip; comparing pins instead would hold it at zero all delay long
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      raw_seen_q <= 1'b0;
      dead_q <= 8'hff;
    end else begin
      raw_seen_q <= out_raw_q;
      if (out_raw_q != raw_seen_q) begin
        dead_q <= 8'h01;
      end else if (dead_q != 8'hff) begin
        dead_q <= dead_q + 8'h01;
      end
    end
  end

  // cycles since the last raw flip; a fresh flip reads as zero so a stale count never skips the delay
  assign dead_now = (out_raw_q != raw_seen_q) ? 8'h00 : dead_q;

  // pins; only the move to the active level waits out the dead time
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      out_q <= 1'b0;
      comp_q <= 1'b1;
    end else if (mode != tmcp_pkg::TMCP_PWM_DUAL || !en) begin
      out_q <= out_raw_q;
      comp_q <= !out_raw_q;
    end else begin
      // inactive level applies at once, active level after delay
      if (out_raw_q == pol) begin
        out_q <= pol;
      end else if (dead_now >= dead_cycles(ctl0_q.dead_time_select)) begin
        out_q <= !pol;
      end
      if (out_raw_q != pol) begin
        comp_q <= pol;
      end else if (dead_now >= dead_cycles(ctl0_q.dead_time_select)) begin
        comp_q <= !pol;
      end
    end
  end

  // sticky status, write one clears, a new event wins over the clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~((wr && idx == `TMCP_IDX_STATUS) ? pwdata[`TMCP_ST_W-1:0] : '0)) | ev;
    end
  end

  // interrupt mask
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mask_q <= '0;
    end else if (wr && idx == `TMCP_IDX_MASK) begin
      mask_q <= pwdata[`TMCP_ST_W-1:0];
    end
  end

  assign irq = |(status_q & mask_q);

  // apb: one wait state, read data registered in that cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ready_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else if (psel && penable && !ready_q) begin
      ready_q <= 1'b1;
      if (idx == `TMCP_IDX_COUNT) begin
        rdata_q <= {16'h0000, count_q};
      end else if (idx == `TMCP_IDX_RELOAD) begin
        rdata_q <= {16'h0000, reload_q};
      end else if (idx == `TMCP_IDX_PWM) begin
        rdata_q <= {16'h0000, pwm_q};
      end else if (idx == `TMCP_IDX_CTL0) begin
        rdata_q <= {24'h000000, ctl0_q};
      end else if (idx == CTL1_INDEX) begin
        rdata_q <= {24'h000000, ctl1_q};
      end else if (idx == `TMCP_IDX_STATUS) begin
        rdata_q <= {29'h00000000, status_q};
      end else if (idx == `TMCP_IDX_MASK) begin
        rdata_q <= {29'h00000000, mask_q};
      end else begin
        rdata_q <= 32'h00000000;
      end
    end else begin
      ready_q <= 1'b0;
    end
  end

  assign pready = ready_q;
  assign prdata = rdata_q;
  assign pslverr = ready_q && !mapped;
  assign timer_out = out_q;
  assign timer_out_comp = comp_q;

endmodule

// [test/tmcp_timer_checker.sv]
// Purpose: port-level assertions for the timer block
// Assumes: one clock, async active-high reset, apb slave answers itself
// Notes: control one and mask are shadowed from completed apb writes
`timescale 1ns/1ns
`include "tmcp_cfg.svh"
module tmcp_timer_checker #(
  parameter logic [11:0] CTL1_INDEX = `TMCP_IDX_CTL1_T0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_input,
  input wire logic timer_out,
  input wire logic timer_out_comp,
  input wire logic irq
);
  logic [7:0] ctl1_q;
  logic [2:0] mask_q;
  logic [1:0] idle_q;
  logic wr_done;
  logic mapped;
  logic [11:0] idx;
  assign idx = paddr[13:2];
  assign wr_done = psel && penable && pready && pwrite;
  assign mapped = idx == `TMCP_IDX_COUNT || idx == `TMCP_IDX_RELOAD || idx == `TMCP_IDX_PWM
    || idx == `TMCP_IDX_CTL0 || idx == CTL1_INDEX || idx == `TMCP_IDX_STATUS || idx == `TMCP_IDX_MASK;
  // shadows follow the write at its completing edge, as the slave does
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctl1_q <= 8'h00;
      mask_q <= 3'h0;
    end else if (wr_done && idx == CTL1_INDEX) begin
      ctl1_q <= pwdata[7:0];
    end else if (wr_done && idx == `TMCP_IDX_MASK) begin
      mask_q <= pwdata[2:0];
    end
  end
  // settle time after any write, so output lag never trips the level check
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      idle_q <= 2'h0;
    end else if (wr_done || ctl1_q[7]) begin
      idle_q <= 2'h0;
    end else if (idle_q != 2'h3) begin
      idle_q <= idle_q + 2'h1;
    end
  end
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (reset);
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  chk_ready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("pready late after access edge");
  chk_ready_cause: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready without a pending access");
  chk_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  chk_err_alone: assert property (pslverr |-> pready)
    else $error("pslverr outside completion");
  chk_read_width: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  chk_err_data: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_idle_level: assert property (idle_q == 2'h3 |-> timer_out == ctl1_q[6] && timer_out_comp == !ctl1_q[6])
    else $error("disabled output level wrong");
  chk_irq_masked: assert property (mask_q == 3'h0 |-> !irq)
    else $error("irq high with all sources masked");
  cover property (pslverr);
  cover property (irq);
  cover property (idle_q == 2'h3 && ctl1_q[6]);
endmodule

bind tmcp_timer tmcp_timer_checker #(.CTL1_INDEX(CTL1_INDEX)) u_chk (.clock, .reset, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_input, .timer_out, .timer_out_comp, .irq);

// [test/tmcp_pin_model.sv]
// Purpose: external source on the timer input pin
// Assumes: bursts of toggles launched just after a clock edge
// Notes: pin stands still between bursts; gap 1 is the fastest source
`timescale 1ns/1ns
module tmcp_pin_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic load,
  input wire logic [7:0] toggles,
  input wire logic [7:0] gap,
  output logic timer_input,
  output logic busy
);
  logic [7:0] left_q;
  logic [7:0] wait_q;
  logic [7:0] gap_q;
  assign busy = left_q != 8'h00;
  // one toggle every gap cycles until the burst is spent
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      timer_input <= 1'h0;
      left_q <= 8'h00;
      wait_q <= 8'h01;
      gap_q <= 8'h01;
    end else if (load) begin
      left_q <= toggles;
      wait_q <= gap;
      gap_q <= gap;
    end else if (busy && wait_q == 8'h01) begin
      timer_input <= !timer_input;
      left_q <= left_q - 8'h01;
      wait_q <= gap_q;
    end else if (busy) begin
      wait_q <= wait_q - 8'h01;
    end
  end
endmodule

// [test/test_timer_mode_and_polarity_logic.sv]
// Purpose: self-checking bench for the timer block
// Assumes: 25 MHz clock, expected values worked out here from the rules
// Notes: the input pin level carries over from one test to the next
`timescale 1ns/1ns
`include "tmcp_cfg.svh"
module test_timer_mode_and_polarity_logic;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timer_input;
  logic timer_out;
  logic timer_out_comp;
  logic irq;
  logic load = 1'h0;
  logic [7:0] toggles = 8'h00;
  logic [7:0] gap = 8'h01;
  logic busy;
  logic [31:0] rd;
  logic er;
  int error_cnt = 0;
  int n_tests = 0;
  int n;
  int r;
  int s;
  int k;
  logic [11:0] ix[$] = '{12'hf00, 12'hf02, 12'hf04, 12'hf06, 12'hf07, 12'hf10, 12'hf11};
  logic [31:0] q[$] = '{32'h1, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  always #20 clock = !clock;

  tmcp_timer u_dut (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .timer_input, .timer_out, .timer_out_comp, .irq);
  tmcp_pin_model u_pin (.clock, .reset, .load, .toggles, .gap, .timer_input, .busy);

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hang(input string what);
    error_cnt++;
    $display("MISMATCH %s expected done seen timeout", what);
    tally_and_finish();
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] i, input logic [31:0] d);
    int t;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    t = 0;
    do begin
      @(posedge clock);
      t++;
    end while (pready !== 1'h1 && t < 16);
    if (t >= 16) hang("pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // counts edges until the chosen output moves
  task automatic waitchg(input logic comp, output int cyc);
    logic o;
    o = comp ? timer_out_comp : timer_out;
    cyc = 0;
    do begin
      @(posedge clock);
      cyc++;
    end while ((comp ? timer_out_comp : timer_out) === o && cyc < 4000);
    if (cyc >= 4000) hang("output edge");
  endtask

  // burst of input toggles from the pin model
  task automatic pins(input int t, input int g);
    int c;
    @(posedge clock);
    toggles <= 8'(t);
    gap <= 8'(g);
    load <= 1'h1;
    @(posedge clock);
    load <= 1'h0;
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (busy !== 1'h0 && c < 3000);
    if (c >= 3000) hang("pin burst");
    repeat (3) @(posedge clock);
  endtask

  // disable, configure, load, then enable
  task automatic setup(input int m, input int p, input int pr, input int dt, input int rel, input int pw);
    logic [31:0] c1;
    c1 = {24'h0, 1'h0, 1'(p), 3'(pr), 3'(m)};
    apb(1'h1, `TMCP_IDX_CTL1_T0, c1);
    apb(1'h1, `TMCP_IDX_CTL0, {24'h0, 1'(m >> 3), 3'h0, 3'(dt), 1'h0});
    apb(1'h1, `TMCP_IDX_COUNT, 32'h1);
    apb(1'h1, `TMCP_IDX_RELOAD, 32'(rel));
    apb(1'h1, `TMCP_IDX_PWM, 32'(pw));
    apb(1'h1, `TMCP_IDX_CTL1_T0, c1 | 32'h80);
  endtask

  initial begin
    void'($urandom(74));
    repeat (4) @(posedge clock);
    reset <= 1'h0;
    // reset values, then a refused index
    foreach (ix[j]) begin
      apb(1'h0, ix[j], 32'h0);
      chk("reset value", q[j], rd);
    end
    apb(1'h0, 12'hf01, 32'h0);
    chk("unmapped read", 32'h0, rd);
    chk("unmapped error", 32'h1, 32'(er));
    $display("test registers done");
    // continuous toggling across prescales, irq raise, clear and mask
    for (s = 0; s < 4; s++) begin
      r = 8 + $urandom % 32;
      apb(1'h1, `TMCP_IDX_MASK, 32'h1);
      setup(1, s % 2, s, 0, r, 0);
      waitchg(1'h0, n);
      waitchg(1'h0, n);
      chk("toggle period", 32'(r << s), 32'(n));
      chk("irq raised", 32'h1, 32'(irq));
      apb(1'h1, `TMCP_IDX_STATUS, 32'h1);
      @(posedge clock);
      chk("irq cleared", 32'h0, 32'(irq));
      apb(1'h1, `TMCP_IDX_MASK, 32'h0);
      waitchg(1'h0, n);
      apb(1'h0, `TMCP_IDX_STATUS, 32'h0);
      chk("status sticky", 32'h1, rd & 32'h1);
      apb(1'h1, `TMCP_IDX_CTL1_T0, 32'((s % 2) << 6 | s << 3 | 1));
      apb(1'h1, `TMCP_IDX_STATUS, 32'h7);
      repeat (3) @(posedge clock);
      chk("idle level", 32'(s % 2), 32'(timer_out));
    end
    $display("test continuous done");
    // counter modes count only the polarity-selected edge
    for (s = 0; s < 2; s++) begin
      n = 3 + $urandom % 5;
      setup(s ? 10 : 2, s, 0, 0, 16'hffff, 0);
      pins(2 * n + 1, 1 + $urandom % 4);
      apb(1'h0, `TMCP_IDX_COUNT, 32'h0);
      chk("edge count", 32'(n + 2), rd);
      apb(1'h1, `TMCP_IDX_CTL1_T0, 32'h0);
    end
    $display("test counter done");
    // capture/compare: armed, capture, then compare reach
    apb(1'h1, `TMCP_IDX_MASK, 32'h2);
    setup(7, 0, 0, 0, 300, 0);
    repeat (20) @(posedge clock);
    apb(1'h0, `TMCP_IDX_COUNT, 32'h0);
    chk("count before start", 32'h1, rd);
    pins(3, 20);
    apb(1'h0, `TMCP_IDX_PWM, 32'h0);
    chk("capture near 40", 32'h1, 32'(rd >= 39 && rd <= 41));
    chk("capture irq", 32'h1, 32'(irq));
    apb(1'h0, `TMCP_IDX_CTL0, 32'h0);
    chk("cause set", 32'h1, rd & 32'h1);
    k = 0;
    do begin
      apb(1'h0, `TMCP_IDX_STATUS, 32'h0);
      k++;
    end while (rd[0] !== 1'h1 && k < 200);
    if (k >= 200) hang("compare reach");
    apb(1'h0, `TMCP_IDX_CTL0, 32'h0);
    chk("cause clear", 32'h0, rd & 32'h1);
    apb(1'h1, `TMCP_IDX_CTL1_T0, 32'h0);
    apb(1'h1, `TMCP_IDX_STATUS, 32'h7);
    $display("test capture done");
    // dual outputs: active level waits out the dead time
    for (s = 6; s < 8; s++) begin
      setup(8, 0, 0, s, 400, 100);
      waitchg(1'h1, n);
      chk("comp at match", 32'h0, 32'(timer_out_comp));
      waitchg(1'h0, n);
      chk("dead time", 32'(1 << s), 32'(n));
      apb(1'h1, `TMCP_IDX_CTL1_T0, 32'h0);
      repeat (3) @(posedge clock);
      chk("dual idle", 32'h1, 32'(!timer_out && timer_out_comp));
    end
    $display("test dual done");
    // gated, polarity 1: gate interrupt only in the first pass, rising edge restarts at 0001
    setup(6, 1, 0, 0, 16'hffff, 0);
    for (s = 0; s < 2; s++) begin
      apb(1'h1, `TMCP_IDX_COUNT, 32'h100);
      apb(1'h1, `TMCP_IDX_STATUS, 32'h7);
      pins(2, 20);
      apb(1'h0, `TMCP_IDX_COUNT, 32'h0);
      chk("gate restart", `TMCP_RESTART, rd);
      apb(1'h0, `TMCP_IDX_STATUS, 32'h0);
      chk("gate event", 32'(1 - s), rd >> 2);
      apb(1'h1, `TMCP_IDX_CTL0, 32'h60);
    end
    $display("test gated done");
    // single pwm: high from match until reload
    r = 10 + $urandom % 20;
    setup(3, 0, 0, 0, r + 30, r);
    waitchg(1'h0, n);
    chk("pwm at match", 32'h1, 32'(timer_out));
    waitchg(1'h0, n);
    chk("pwm high time", 32'h1e, 32'(n));
    chk("pwm at reload", 32'h0, 32'(timer_out));
    $display("test pwm done");
    // capture mode, polarity 1: only the falling edge captures
    setup(4, 1, 0, 0, 16'hffff, 0);
    for (s = 0; s < 2; s++) begin
      apb(1'h1, `TMCP_IDX_STATUS, 32'h7);
      pins(1, 1);
      apb(1'h0, `TMCP_IDX_STATUS, 32'h0);
      chk("capture edge", 32'(1 - s), (rd >> 1) & 32'h1);
    end
    $display("test capture edge done");
    tally_and_finish();
  end
endmodule
